// >>> hw/wrap_coordinate_zone_pulse.sv
// Wrapped coordinate, wrap checks and zone boundary pulse behind an AXI4-Lite slave
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
module wrap_coordinate_zone_pulse
  import wrap_zone_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] i_pos,
  input wire logic i_preset,
  output logic [31:0] o_wrap_pos,
  output logic o_zone_boundary_pulse,
  output logic o_wrap_active,
  output logic o_wrap_info_err,
  output logic o_wrap_alarm
);
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic manual_ff;
  logic wrap_en_ff;
  logic [RANGE_W-1:0] range_ff;
  logic [GEAR_W-1:0] gear_a_ff;
  logic [GEAR_W-1:0] gear_b_ff;
  logic [RATIO_W-1:0] ratio_ff;
  logic [OFS_W-1:0] ofs_ff;
  logic [DIVS_W-1:0] divs_ff;
  logic pend_ff;
  logic pend_alarm_ff;
  logic boot_ff;
  eval_state_t state_ff;
  logic div_go_ff;
  logic [DIV_DW-1:0] div_num_ff;
  logic [DIV_DW-1:0] div_den_ff;
  logic c1_ok_ff;
  logic c2_ok_ff;
  logic eval_alarm_ff;
  logic [31:0] steps_ff;
  logic [31:0] ratio_ofs_ff;
  logic signed [31:0] lower_ff;
  logic signed [31:0] upper_ff;
  logic active_ff;
  logic info_ff;
  logic alarm_ff;
  logic done_pulse_ff;
  logic pos_init_ff;
  logic [31:0] prev_pos_ff;
  logic signed [31:0] wrap_pos_ff;
  logic signed [63:0] zone_acc_ff;
  logic zone_pulse_ff;
  logic div_done;
  logic [DIV_DW-1:0] div_quo;
  logic [DIV_DW-1:0] div_rem;
  logic do_write;
  logic do_read;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic wr_setting;
  logic wr_config;
  logic wr_alarm_clr;
  logic eff_wrap_en;
  logic [RANGE_W-1:0] eff_range;
  logic [GEAR_W-1:0] eff_gear_a;
  logic [GEAR_W-1:0] eff_gear_b;
  logic [RATIO_W-1:0] eff_ratio;
  logic [OFS_W-1:0] eff_ofs;
  logic [DIVS_W-1:0] eff_divs;
  logic signed [33:0] calc_lower;
  logic signed [33:0] calc_upper;
  logic home_ok;
  logic eval_valid;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic signed [31:0] delta;
  logic signed [32:0] wsum;
  logic signed [63:0] zsum;
  logic signed [63:0] steps64;

  wrap_divider #(.W(DIV_DW)) u_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(div_go_ff),
    .i_num(div_num_ff),
    .i_den(div_den_ff),
    .o_done(div_done),
    .o_quo(div_quo),
    .o_rem(div_rem)
  );

  // Bus write path: address and data are taken in either order
  assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  assign do_read = arready_ff && i_arvalid;

  always_comb begin
    wval = '0;
    case (aw_addr_ff)
      ADDR_CTRL: wval = {29'h0, 1'b0, wrap_en_ff, manual_ff};
      ADDR_RANGE: wval = {17'h0, range_ff};
      ADDR_GEAR_A: wval = {16'h0, gear_a_ff};
      ADDR_GEAR_B: wval = {16'h0, gear_b_ff};
      ADDR_RATIO: wval = {18'h0, ratio_ff};
      ADDR_OFS: wval = {{2{ofs_ff[OFS_W-1]}}, ofs_ff};
      ADDR_DIVS: wval = {3'h0, divs_ff};
      default: wval = '0;
    endcase
    wval = (wval & ~wmask) | (w_data_ff & wmask);
  end

  assign wr_setting = do_write && (aw_addr_ff <= ADDR_DIVS);
  assign wr_config = do_write && (aw_addr_ff == ADDR_CTRL) && w_strb_ff[0]
                     && w_data_ff[CTRL_CONFIG_BIT];
  assign wr_alarm_clr = do_write && (aw_addr_ff == ADDR_STATUS) && w_strb_ff[0]
                        && w_data_ff[STAT_ALARM_BIT];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (awready_ff && i_awvalid) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= i_awaddr;
        awready_ff <= 1'b0;
      end
      if (wready_ff && i_wvalid) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= i_wdata;
        w_strb_ff <= i_wstrb;
        wready_ff <= 1'b0;
      end
      if (do_write) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (aw_addr_ff <= ADDR_STATUS && aw_addr_ff[1:0] == 2'h0) ?
                    RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_ff && i_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Setting registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      manual_ff <= MANUAL_RST;
      wrap_en_ff <= WRAP_EN_RST;
      range_ff <= RANGE_RST;
      gear_a_ff <= GEAR_RST;
      gear_b_ff <= GEAR_RST;
      ratio_ff <= RATIO_RST;
      ofs_ff <= OFS_RST;
      divs_ff <= DIVS_RST;
    end else if (do_write) begin
      case (aw_addr_ff)
        ADDR_CTRL: begin
          manual_ff <= wval[CTRL_MANUAL_BIT];
          wrap_en_ff <= wval[CTRL_WRAP_EN_BIT];
        end
        ADDR_RANGE: range_ff <= wval[RANGE_W-1:0];
        ADDR_GEAR_A: gear_a_ff <= wval[GEAR_W-1:0];
        ADDR_GEAR_B: gear_b_ff <= wval[GEAR_W-1:0];
        ADDR_RATIO: ratio_ff <= (wval[31:0] > {18'h0, RATIO_FULL}) ?
                                RATIO_FULL : wval[RATIO_W-1:0]; // [R14]
        ADDR_OFS: ofs_ff <= wval[OFS_W-1:0];
        ADDR_DIVS: divs_ff <= (wval[DIVS_W-1:0] == '0) ? DIVS_RST :
                              wval[DIVS_W-1:0]; // [R12]
        default: ;
      endcase
    end
  end

  // Encoder-prioritized values stand in unless manual setting is chosen
  assign eff_wrap_en = manual_ff ? wrap_en_ff : WRAP_EN_RST; // [R13]
  assign eff_range = manual_ff ? range_ff : RANGE_RST;
  assign eff_gear_a = manual_ff ? gear_a_ff : GEAR_RST;
  assign eff_gear_b = manual_ff ? gear_b_ff : GEAR_RST;
  assign eff_ratio = manual_ff ? ratio_ff : RATIO_RST;
  assign eff_ofs = manual_ff ? ofs_ff : OFS_RST;
  assign eff_divs = manual_ff ? divs_ff : DIVS_RST;

  // A request arriving while one is served is kept, so the last settings win
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      boot_ff <= 1'b1;
      pend_ff <= 1'b0;
      pend_alarm_ff <= 1'b0;
    end else begin
      boot_ff <= 1'b0;
      if (wr_setting || wr_config || boot_ff) begin
        pend_ff <= 1'b1;
        pend_alarm_ff <= pend_alarm_ff || wr_config || boot_ff;
      end else if (state_ff == S_IDLE && pend_ff) begin
        pend_ff <= 1'b0;
        pend_alarm_ff <= 1'b0;
      end
    end
  end

  // Bounds: ratio offset pulls the range negative, then the step offset moves it
  assign calc_lower = 34'(signed'(eff_ofs)) - $signed({2'b0, ratio_ofs_ff}); // [R7] [R8]
  assign calc_upper = calc_lower + $signed({2'b0, steps_ff}) - 34'sd1;
  assign home_ok = (calc_lower <= 34'sd0) && (calc_upper >= 34'sd0); // [R9]
  assign eval_valid = c1_ok_ff && c2_ok_ff && home_ok;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= S_IDLE;
      div_go_ff <= 1'b0;
      div_num_ff <= '0;
      div_den_ff <= '0;
      c1_ok_ff <= 1'b0;
      c2_ok_ff <= 1'b0;
      eval_alarm_ff <= 1'b0;
      steps_ff <= '0;
      ratio_ofs_ff <= '0;
      lower_ff <= '0;
      upper_ff <= '0;
      active_ff <= 1'b0;
      info_ff <= 1'b0;
      done_pulse_ff <= 1'b0;
    end else begin
      div_go_ff <= 1'b0;
      done_pulse_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (pend_ff) begin
            eval_alarm_ff <= pend_alarm_ff;
            div_num_ff <= DIV_DW'(SPAN_TENTHS);
            div_den_ff <= DIV_DW'(eff_range);
            div_go_ff <= 1'b1;
            state_ff <= S_CHK1;
          end
        end
        S_CHK1: begin
          if (div_done) begin
            c1_ok_ff <= (div_rem == '0) && (eff_range != '0); // [R1]
            div_num_ff <= DIV_DW'(eff_range) * DIV_DW'(eff_gear_b) * DIV_DW'(STEPS_PER_TENTH);
            div_den_ff <= DIV_DW'(eff_gear_a);
            div_go_ff <= 1'b1;
            state_ff <= S_CHK2;
          end
        end
        S_CHK2: begin
          if (div_done) begin
            // Whole steps per range, nonzero and within a signed 32-bit coordinate
            c2_ok_ff <= (div_rem == '0) && (eff_gear_a != '0) && (div_quo != '0)
                        && (div_quo[DIV_DW-1:31] == '0); // [R3]
            steps_ff <= div_quo[31:0];
            div_num_ff <= DIV_DW'(div_quo[30:0]) * DIV_DW'(eff_ratio);
            div_den_ff <= DIV_DW'(RATIO_FULL);
            div_go_ff <= 1'b1;
            state_ff <= S_OFS;
          end
        end
        S_OFS: begin
          if (div_done) begin
            ratio_ofs_ff <= div_quo[31:0]; // [R7]
            state_ff <= S_DONE;
          end
        end
        S_DONE: begin
          lower_ff <= calc_lower[31:0];
          upper_ff <= calc_upper[31:0];
          active_ff <= eff_wrap_en && eval_valid; // [R2] [R4]
          info_ff <= eff_wrap_en && !eval_valid; // [R4] [R9]
          done_pulse_ff <= 1'b1;
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // Alarm is sticky; a new error beats a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      alarm_ff <= 1'b0;
    end else if (state_ff == S_DONE && eval_alarm_ff && eff_wrap_en && !eval_valid) begin
      alarm_ff <= 1'b1; // [R5]
    end else if (wr_alarm_clr) begin
      alarm_ff <= 1'b0;
    end
  end

  // Motion since last cycle; assumed smaller than one wrap range per clock
  assign delta = $signed(i_pos - prev_pos_ff);
  assign wsum = 33'(wrap_pos_ff) + 33'(delta);
  assign steps64 = $signed({32'h0, steps_ff});
  assign zsum = zone_acc_ff + 64'(delta) * $signed({35'h0, eff_divs});

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pos_init_ff <= 1'b1;
      prev_pos_ff <= '0;
    end else begin
      pos_init_ff <= 1'b0;
      prev_pos_ff <= i_pos;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wrap_pos_ff <= '0;
    end else if (!active_ff) begin
      wrap_pos_ff <= $signed(i_pos);
    end else if (i_preset) begin
      wrap_pos_ff <= '0;
    end else if (done_pulse_ff && (wrap_pos_ff > upper_ff || wrap_pos_ff < lower_ff)) begin
      wrap_pos_ff <= '0;
    end else if (!pos_init_ff) begin
      if (wsum > 33'(upper_ff)) begin
        wrap_pos_ff <= 32'(wsum - 33'(steps_ff)); // [R15]
      end else if (wsum < 33'(lower_ff)) begin
        wrap_pos_ff <= 32'(wsum + 33'(steps_ff)); // [R15]
      end else begin
        wrap_pos_ff <= wsum[31:0];
      end
    end
  end

  // Position scaled by the division count, kept modulo the range; each wrap is a boundary
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      zone_acc_ff <= '0;
      zone_pulse_ff <= 1'b0;
    end else if (!active_ff || i_preset || done_pulse_ff || pos_init_ff
                 || state_ff == S_DONE) begin
      zone_acc_ff <= '0;
      zone_pulse_ff <= 1'b0; // [R11]
    end else if (zsum >= steps64) begin
      zone_acc_ff <= zsum - steps64;
      zone_pulse_ff <= 1'b1; // [R10]
    end else if (zsum < 64'sd0) begin
      zone_acc_ff <= zsum + steps64;
      zone_pulse_ff <= 1'b1; // [R10]
    end else begin
      zone_acc_ff <= zsum;
      zone_pulse_ff <= 1'b0;
    end
  end

  // Bus read path
  always_comb begin
    rd_hit = 1'b1;
    case (i_araddr)
      ADDR_CTRL: rd_mux = {30'h0, wrap_en_ff, manual_ff};
      ADDR_RANGE: rd_mux = {17'h0, range_ff};
      ADDR_GEAR_A: rd_mux = {16'h0, gear_a_ff};
      ADDR_GEAR_B: rd_mux = {16'h0, gear_b_ff};
      ADDR_RATIO: rd_mux = {18'h0, ratio_ff};
      ADDR_OFS: rd_mux = {{2{ofs_ff[OFS_W-1]}}, ofs_ff};
      ADDR_DIVS: rd_mux = {3'h0, divs_ff};
      ADDR_STATUS: rd_mux = {28'h0, (state_ff != S_IDLE) || pend_ff, alarm_ff,
                             info_ff, active_ff};
      ADDR_LOWER: rd_mux = lower_ff;
      ADDR_UPPER: rd_mux = upper_ff;
      ADDR_POS: rd_mux = wrap_pos_ff;
      default: begin
        rd_mux = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else begin
      if (do_read) begin
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rvalid_ff <= 1'b1;
        arready_ff <= 1'b0;
      end
      if (rvalid_ff && i_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  assign o_awready = awready_ff;
  assign o_wready = wready_ff;
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;
  assign o_arready = arready_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;
  assign o_wrap_pos = wrap_pos_ff;
  assign o_zone_boundary_pulse = zone_pulse_ff;
  assign o_wrap_active = active_ff;
  assign o_wrap_info_err = info_ff;
  assign o_wrap_alarm = alarm_ff;
endmodule : wrap_coordinate_zone_pulse

// >>> hw/wrap_zone_pkg.sv
// Constants, register map and types of the wrapped coordinate block
// Functional notes
// [R1] Wrap range must divide evenly into the 1800 rev absolute coordinate span.
// [R2] With both conditions met, wrapping runs endlessly while home stays put.
// [R3] Range times gear B over gear A times 1000 must give whole steps.
// [R4] Wrap enabled but a condition fails: raise info flag, do not wrap.
// [R5] Configuration or power-up while the info flag stands raises the alarm.
// [R6] Host should preset or home after changing wrap enable or range.
// [R7] Ratio offset shifts range negative by ratio times range; 50% centres home.
// [R8] Signed step offset then shifts both bounds.
// [R9] Offset leaving home outside the range raises the info flag.
// [R10] Boundary pulse at each even division point of the range, from home.
// [R11] Boundary pulse only while wrapping is enabled.
// [R12] Division count accepted from 1 to 536,870,911, default 1.
// [R13] Manual wrap values apply only in manual mode, else encoder defaults.
// [R14] Offset ratio is 0 to 10000, one unit per 0.01 percent.
// [R15] Passing the upper bound lands on lower bound, and vice versa.
package wrap_zone_pkg;
  localparam int ADDR_W = 8;
  localparam int DIV_DW = 48;
  localparam int RANGE_W = 15;
  localparam int GEAR_W = 16;
  localparam int RATIO_W = 14;
  localparam int OFS_W = 30;
  localparam int DIVS_W = 29;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RANGE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_GEAR_A = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_GEAR_B = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_RATIO = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_DIVS = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_LOWER = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_UPPER = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_POS = 8'h28;
  localparam int CTRL_MANUAL_BIT = 0;
  localparam int CTRL_WRAP_EN_BIT = 1;
  localparam int CTRL_CONFIG_BIT = 2;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_INFO_BIT = 1;
  localparam int STAT_ALARM_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  // Range is held in tenths of a revolution
  localparam logic [RANGE_W-1:0] SPAN_TENTHS = 15'h4650;
  localparam logic [7:0] STEPS_PER_TENTH = 8'h64;
  localparam logic [RATIO_W-1:0] RATIO_FULL = 14'h2710;
  localparam logic [DIVS_W-1:0] DIVS_MAX = 29'h1fffffff;
  localparam logic MANUAL_RST = 1'b0;
  localparam logic WRAP_EN_RST = 1'b1;
  localparam logic [RANGE_W-1:0] RANGE_RST = 15'h0064;
  localparam logic [GEAR_W-1:0] GEAR_RST = 16'h0001;
  localparam logic [RATIO_W-1:0] RATIO_RST = 14'h1388;
  localparam logic [OFS_W-1:0] OFS_RST = 30'h00000000;
  localparam logic [DIVS_W-1:0] DIVS_RST = 29'h00000001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_CHK1 = 5'b00010,
    S_CHK2 = 5'b00100,
    S_OFS = 5'b01000,
    S_DONE = 5'b10000
  } eval_state_t;
endpackage : wrap_zone_pkg

// >>> hw/wrap_divider.sv
// Iterative restoring divider, one quotient bit per clock
module wrap_divider #(
  parameter int W = 48
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [W-1:0] i_num,
  input wire logic [W-1:0] i_den,
  output logic o_done,
  output logic [W-1:0] o_quo,
  output logic [W-1:0] o_rem
);
  logic [W:0] rem_ff;
  logic [W-1:0] quo_ff;
  logic [W-1:0] den_ff;
  logic [$clog2(W+1)-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  logic [W:0] rem_sh;
  assign rem_sh = {rem_ff[W-1:0], quo_ff[W-1]};
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rem_ff <= '0;
      quo_ff <= '0;
      den_ff <= '0;
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (i_start) begin
        rem_ff <= '0;
        quo_ff <= i_num;
        den_ff <= i_den;
        cnt_ff <= ($clog2(W+1))'(W);
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (rem_sh >= {1'b0, den_ff}) begin
          rem_ff <= rem_sh - {1'b0, den_ff};
          quo_ff <= {quo_ff[W-2:0], 1'b1};
        end else begin
          rem_ff <= rem_sh;
          quo_ff <= {quo_ff[W-2:0], 1'b0};
        end
        cnt_ff <= cnt_ff - 1'b1;
        if (cnt_ff == 1) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end
  assign o_done = done_ff;
  assign o_quo = quo_ff;
  assign o_rem = rem_ff[W-1:0];
endmodule : wrap_divider

// >>> dv/wrap_zone_host.sv
// Host controller model: steps the raw position and counts boundary pulses
module wrap_zone_host (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_up,
  input wire logic [15:0] i_n,
  input wire logic i_home,
  input wire logic i_pulse,
  output logic [31:0] o_pos,
  output logic o_preset,
  output logic o_busy,
  output logic [15:0] o_pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] pos_ff;
  logic [15:0] left_ff;
  logic [15:0] cnt_ff;
  logic busy_ff;
  logic home_ff;
  assign o_pos = pos_ff;
  assign o_busy = busy_ff;
  assign o_pulses = cnt_ff;
  assign o_preset = home_ff;
  // One step a clock keeps every delta far below the range
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pos_ff <= 32'h0;
      left_ff <= 16'h0;
      busy_ff <= 1'b0;
    end else if (i_go) begin
      left_ff <= i_n;
      busy_ff <= 1'b1;
    end else if (busy_ff) begin
      pos_ff <= i_up ? pos_ff + 32'h1 : pos_ff - 32'h1;
      left_ff <= left_ff - 16'h1;
      busy_ff <= left_ff != 16'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst || i_go) begin
      cnt_ff <= 16'h0;
    end else begin
      cnt_ff <= cnt_ff + 16'(i_pulse);
    end
  end
  // Preset is only sent on request, one clock after each i_home
  always_ff @(posedge i_clk) begin
    home_ff <= i_home && !i_rst;
  end
endmodule : wrap_zone_host

// >>> dv/wrap_coordinate_zone_pulse_monitor.sv
// Port checker of the wrapped coordinate block
module wrap_coordinate_zone_pulse_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_awvalid,
  input wire logic i_wvalid,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic i_bready,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic i_rready,
  input wire logic [31:0] i_pos,
  input wire logic i_preset,
  input wire logic [31:0] o_wrap_pos,
  input wire logic o_zone_boundary_pulse,
  input wire logic o_wrap_active,
  input wire logic o_wrap_info_err,
  input wire logic o_wrap_alarm
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  pulse_needs_act_a: assert property (o_zone_boundary_pulse |-> o_wrap_active)
    else $error("boundary pulse while wrap inactive");
  act_info_excl_a: assert property (!(o_wrap_active && o_wrap_info_err))
    else $error("wrap active with setting error");
  raw_follow_a: assert property (!o_wrap_active && $past(!o_wrap_active)
    && $past(!o_wrap_active, 2) && !$past(i_rst, 2) |-> o_wrap_pos == $past(i_pos))
    else $error("inactive position not raw copy");
  still_no_pulse_a: assert property (o_wrap_active && $past(o_wrap_active)
    && $stable(o_wrap_pos) |-> !o_zone_boundary_pulse)
    else $error("boundary pulse without motion");
  preset_home_a: assert property (o_wrap_active && i_preset
    |=> o_wrap_pos == 32'h0 || !o_wrap_active)
    else $error("preset did not home position");
  alarm_sticky_a: assert property (o_wrap_alarm && o_awready && o_wready
    && !i_awvalid && !i_wvalid |=> o_wrap_alarm)
    else $error("alarm dropped without clear");
  alarm_cause_a: assert property ($rose(o_wrap_alarm) |-> o_wrap_info_err)
    else $error("alarm without setting error");
  bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response not held");
  rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data not held");
  ar_block_a: assert property (o_rvalid |-> !o_arready)
    else $error("read address open during answer");
endmodule : wrap_coordinate_zone_pulse_monitor
bind wrap_coordinate_zone_pulse wrap_coordinate_zone_pulse_monitor u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_awvalid(i_awvalid), .i_wvalid(i_wvalid),
  .o_awready(o_awready), .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
  .i_bready(i_bready), .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
  .i_rready(i_rready), .i_pos(i_pos), .i_preset(i_preset), .o_wrap_pos(o_wrap_pos),
  .o_zone_boundary_pulse(o_zone_boundary_pulse), .o_wrap_active(o_wrap_active),
  .o_wrap_info_err(o_wrap_info_err), .o_wrap_alarm(o_wrap_alarm));

// >>> dv/test_wrap_coordinate_zone_pulse.sv
// Self-checking bench of the wrapped coordinate block
module test_wrap_coordinate_zone_pulse
  import wrap_zone_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, awv, wv, bre, arv, rre, go, up, home;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdata, wpos, pos, d;
  logic [15:0] n, pulses;
  logic [1:0] br, rr, rs;
  logic awr, wr, bv, arr, rv, pulse, act, info, alarm, preset, busy;
  int err_total, n_checks, cyc, pe;
  int tc [7][5] = '{'{10, 1, 1, 5000, 0}, '{144, 3, 1, 5000, 0}, '{10000, 1, 1, 5000, 0},
    '{5, 3, 1, 5000, 0}, '{10, 1, 1, 0, 100}, '{10, 1, 1, 2500, -100}, '{5, 1, 2, 5000, 0}};
  wrap_coordinate_zone_pulse u_wrap_coordinate_zone_pulse (.i_clk(clk), .i_rst(rst),
    .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf),
    .i_wvalid(wv), .o_wready(wr), .o_bresp(br), .o_bvalid(bv), .i_bready(bre),
    .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata), .o_rresp(rr),
    .o_rvalid(rv), .i_rready(rre), .i_pos(pos), .i_preset(preset), .o_wrap_pos(wpos),
    .o_zone_boundary_pulse(pulse), .o_wrap_active(act), .o_wrap_info_err(info),
    .o_wrap_alarm(alarm));
  wrap_zone_host u_wrap_zone_host (.i_clk(clk), .i_rst(rst), .i_go(go), .i_up(up), .i_n(n),
    .i_home(home), .i_pulse(pulse), .o_pos(pos), .o_preset(preset), .o_busy(busy),
    .o_pulses(pulses));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // A hung handshake ends the run here
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      give_verdict;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && awr) begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (!tw && wr) begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end
    // A late ready makes the slave hold its answer
    repeat ($urandom % 3) @(posedge clk);
    bre <= 1'b1;
    @(posedge clk);
    while (!bv) @(posedge clk);
    rs = br;
    bre <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    @(posedge clk);
    while (!arr) @(posedge clk);
    arv <= 1'b0;
    repeat ($urandom % 3) @(posedge clk);
    rre <= 1'b1;
    @(posedge clk);
    while (!rv) @(posedge clk);
    d = rdata;
    rs = rr;
    rre <= 1'b0;
  endtask : axr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk(d, e);
  endtask : rdc
  task automatic wait_eval;
    repeat (4) @(posedge clk);
    do axr(ADDR_STATUS); while (d[STAT_BUSY_BIT] !== 1'b0);
  endtask : wait_eval
  function automatic logic eval_ok(input longint rt, a, b, r, o, output longint lo, hi);
    longint s;
    s = rt * b * 100 / a;
    lo = o - s * r / 10000;
    hi = lo + s - 1;
    return (18000 % rt == 0) && (rt * b * 100 % a == 0) && s > 0 && lo <= 0 && hi >= 0;
  endfunction : eval_ok
  task automatic cfg(input int rt, a, b, r, o, dv, input logic [31:0] ctl);
    logic ok;
    longint lo, hi;
    axw(ADDR_RANGE, 32'(rt));
    axw(ADDR_GEAR_A, 32'(a));
    axw(ADDR_GEAR_B, 32'(b));
    axw(ADDR_RATIO, 32'(r));
    axw(ADDR_OFS, 32'(o));
    axw(ADDR_DIVS, 32'(dv));
    axw(ADDR_CTRL, ctl);
    wait_eval;
    if (ctl == 32'h3) begin
      ok = eval_ok(rt, a, b, r, o, lo, hi);
      chk(32'(act), 32'(ok));
      chk(32'(info), 32'(!ok));
      if (ok) rdc(ADDR_LOWER, 32'(lo));
      if (ok) rdc(ADDR_UPPER, 32'(hi));
    end
  endtask : cfg
  task automatic mv(input logic u, input int k);
    @(posedge clk);
    up <= u;
    n <= 16'(k);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (3) @(posedge clk);
    pe = u ? pe + k : pe - k;
  endtask : mv
  initial begin
    {rst, awv, wv, bre, arv, rre, go, up, home} = 9'h100;
    {awa, ara, wd, n} = '0;
    {err_total, n_checks, cyc, pe} = '0;
    void'($urandom(52));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_eval;
    chk(32'(act), 32'h1);
    rdc(ADDR_LOWER, 32'hffffec78);
    rdc(ADDR_UPPER, 32'h00001387);
    axr(8'h2c);
    chk(32'(rs), 32'(RESP_SLVERR));
    axw(8'h2c, 32'h0);
    chk(32'(rs), 32'(RESP_SLVERR));
    foreach (tc[i]) cfg(tc[i][0], tc[i][1], tc[i][2], tc[i][3], tc[i][4], 1, 32'h3);
    for (int i = 0; i < 3; i++) cfg(10, 1, 1, int'($urandom % 10000), 0, 1, 32'h3);
    axw(ADDR_DIVS, 32'h0);
    rdc(ADDR_DIVS, 32'h1);
    axw(ADDR_DIVS, 32'(DIVS_MAX));
    rdc(ADDR_DIVS, 32'(DIVS_MAX));
    cfg(10, 1, 1, 5000, 0, 4, 32'h3);
    home <= 1'b1;
    @(posedge clk);
    home <= 1'b0;
    repeat (3) @(posedge clk);
    mv(1'b1, 1000);
    chk(32'(pulses), 32'h4);
    chk(wpos, 32'h0);
    mv(1'b0, 500);
    chk(wpos, 32'hfffffe0c);
    mv(1'b0, 1);
    chk(wpos, 32'h000001f3);
    mv(1'b1, 1);
    chk(wpos, 32'hfffffe0c);
    cfg(10, 1, 1, 5000, 0, 4, 32'h1);
    chk(32'(act | info), 32'h0);
    mv(1'b1, 300);
    chk(32'(pulses), 32'h0);
    chk(wpos, 32'(pe));
    cfg(10000, 1, 1, 5000, 0, 1, 32'h3);
    chk(32'(alarm), 32'h0);
    axw(ADDR_CTRL, 32'h7);
    wait_eval;
    chk(32'(alarm), 32'h1);
    axw(ADDR_STATUS, 32'h4);
    chk(32'(alarm), 32'h0);
    axw(ADDR_CTRL, 32'h0);
    wait_eval;
    chk(32'(act), 32'h1);
    rdc(ADDR_LOWER, 32'hffffec78);
    give_verdict;
  end
endmodule : test_wrap_coordinate_zone_pulse
